// *** pkg/pcr_pkg.sv ***
// Package: constants and types for the privilege check and reset state unit
package pcr_pkg;
    // Machine status word layout
    localparam int          MSW_W        = 16;
    localparam int          MSW_PE       = 0;
    localparam int          MSW_MP       = 1;
    localparam int          MSW_EM       = 2;
    localparam int          MSW_TS       = 3;
    localparam logic [15:0] MSW_LOW_MASK = 16'h000F;
    // Flag word layout
    localparam int          FLG_IF       = 9;
    localparam int          FLG_IO_PRIVILEGE_LIMIT_LO  = 12;
    localparam int          FLG_IO_PRIVILEGE_LIMIT_HI  = 13;
    // Reset values
    localparam logic [15:0] RST_FLAGS    = 16'h0002;
    localparam logic [15:0] RST_MSW      = 16'hFFF0;
    localparam logic [15:0] RST_IP       = 16'hFFF0;
    localparam logic [15:0] RST_CS_SEL   = 16'hF000;
    localparam logic [23:0] RST_CS_BASE  = 24'hFF0000;
    localparam logic [15:0] RST_SEG_SEL  = 16'h0000;
    localparam logic [23:0] RST_SEG_BASE = 24'h000000;
    localparam logic [15:0] RST_LIMIT    = 16'hFFFF;
    localparam logic [23:0] RST_IDT_BASE = 24'h000000;
    localparam logic [15:0] RST_IDT_LIM  = 16'h03FF;
    localparam logic [23:0] RST_FETCH    = 24'hFFFFF0;
    localparam logic [23:0] REAL_BASE_MASK = 24'h0FFFFF;
    // Exception vectors and codes
    localparam logic [7:0]  VEC_GP       = 8'h0D;
    localparam logic [7:0]  VEC_NM       = 8'h07;
    localparam logic [15:0] GP_ERR_CODE  = 16'h0000;
    localparam logic [1:0]  PL_ZERO      = 2'h0;
    // Post-reset interval: three to four clocks; four taken
    localparam logic [2:0]  RST_INTERVAL = 3'h4;
    // Instruction classes presented by the decoder
    typedef enum logic [4:0] {
        OP_NONE, OP_LOAD_GLOBAL_TABLE_REG, OP_LOAD_LOCAL_TABLE_REG, OP_LTR, OP_LOAD_INTERRUPT_TABLE_REG, OP_LOAD_MACHINE_STATUS, OP_CLEAR_TASK_SWITCHED, OP_HLT,
        OP_IN, OP_INW, OP_OUT, OP_OUTW, OP_BLOCK_INPUT_BYTE, OP_INSW, OP_OUTSB, OP_BLOCK_OUTPUT_WORD,
        OP_STI, OP_CLI, OP_LOCK, OP_FLAG_POP, OP_INTERRUPT_RETURN, OP_ESC, OP_WAIT,
        OP_LOAD_CS, OP_OTHER
    } pcr_op_t;
    typedef enum logic [1:0] {
        CLS_PLAIN, CLS_PRIV, CLS_TRUST
    } pcr_cls_t;
endpackage

// *** logic/pcr_class.sv ***
// Instruction classifier: privileged, trusted or plain
`timescale 1ns/10ps
module pcr_class (
    // Decoded instruction
    input  wire pcr_pkg::pcr_op_t  op,
    // Class result
    output pcr_pkg::pcr_cls_t      cls
);
    // Table of privileged and trusted instructions
    always_comb begin
        case (op)
            pcr_pkg::OP_LOAD_GLOBAL_TABLE_REG, pcr_pkg::OP_LOAD_LOCAL_TABLE_REG, pcr_pkg::OP_LTR,
            pcr_pkg::OP_LOAD_INTERRUPT_TABLE_REG, pcr_pkg::OP_LOAD_MACHINE_STATUS, pcr_pkg::OP_CLEAR_TASK_SWITCHED,
            pcr_pkg::OP_HLT: begin
                cls = pcr_pkg::CLS_PRIV;
            end
            pcr_pkg::OP_IN, pcr_pkg::OP_INW, pcr_pkg::OP_OUT, pcr_pkg::OP_OUTW,
            pcr_pkg::OP_BLOCK_INPUT_BYTE, pcr_pkg::OP_INSW, pcr_pkg::OP_OUTSB, pcr_pkg::OP_BLOCK_OUTPUT_WORD,
            pcr_pkg::OP_STI, pcr_pkg::OP_CLI, pcr_pkg::OP_LOCK: begin
                cls = pcr_pkg::CLS_TRUST;
            end
            default: begin
                cls = pcr_pkg::CLS_PLAIN;
            end
        endcase
    end
endmodule

// *** logic/pcr_ext_check.sv ***
// Extension-not-present check from the machine status bits
`timescale 1ns/10ps
module pcr_ext_check (
    // Status bits
    input  wire logic mp,
    input  wire logic em,
    input  wire logic ts,
    // Instruction kind
    input  wire logic is_esc,
    input  wire logic is_wait,
    // Fault request
    output logic      ext_fault
);
    // Escape traps on emulate or on switched task; wait only with monitor set
    always_comb begin
        ext_fault = 1'b0;
        if (is_esc && em) begin
            ext_fault = 1'b1;
        end else if (is_esc && ts) begin
            ext_fault = 1'b1;
        end else if (is_wait && mp && ts) begin
            ext_fault = 1'b1;
        end
        // With only the monitor bit set nothing traps
        if (!ts && !em) begin
            ext_fault = 1'b0;
        end
    end
endmodule

// *** logic/pcr_unit.sv ***
// Privilege check, extension fault and reset state unit
`timescale 1ns/10ps
module pcr_unit (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Instruction issue from decoder
    input  wire logic             issue,
    input  wire pcr_pkg::pcr_op_t op,
    input  wire logic [15:0]      op_data,
    input  wire logic [23:0]      op_base,
    input  wire logic             desc_used,
    input  wire logic [23:0]      desc_addr,
    // Current privilege level
    input  wire logic [1:0]       current_privilege_level,
    // Execution status
    output logic                  run,
    output logic                  fetch_req,
    output logic [23:0]           fetch_addr,
    output logic                  halted,
    output logic                  retired,
    // Fault report
    output logic                  fault,
    output logic [7:0]            fault_vec,
    output logic [15:0]           fault_code,
    // Descriptor write-back request
    output logic                  desc_wb,
    output logic [23:0]           desc_wb_addr,
    // Architectural state
    output logic [15:0]           flags,
    output logic [15:0]           machine_status_word,
    output logic [15:0]           ip,
    output logic [15:0]           cs_sel,
    output logic [23:0]           cs_base,
    output logic [15:0]           seg_sel,
    output logic [23:0]           seg_base,
    output logic [15:0]           seg_limit,
    output logic                  seg_prot,
    output logic [23:0]           idt_base,
    output logic [15:0]           idt_limit
);

////////////////////////////////////////////////////////////////////////////////
// Declarations and helpers

    typedef enum logic [1:0] {
        ST_RESET, ST_INIT, ST_FETCH, ST_RUN
    } pcr_state_t;

    pcr_state_t        state;
    logic [2:0]        init_cnt;
    pcr_pkg::pcr_cls_t cls;
    logic              ext_fault;
    logic              priv_ok;
    logic              trust_ok;
    logic              gp_fault;
    logic              any_fault;
    logic              do_exec;
    logic [1:0]        io_privilege_limit;
    logic              protection_enable_bit;
    logic              extension_present_bit;
    logic              emulate_extension_bit;
    logic              task_switched_bit;
    logic [15:0]       next_flags;
    logic              active;

    assign io_privilege_limit    = flags[pcr_pkg::FLG_IO_PRIVILEGE_LIMIT_HI:pcr_pkg::FLG_IO_PRIVILEGE_LIMIT_LO];
    assign protection_enable_bit = machine_status_word[pcr_pkg::MSW_PE];
    assign extension_present_bit = machine_status_word[pcr_pkg::MSW_MP];
    assign emulate_extension_bit = machine_status_word[pcr_pkg::MSW_EM];
    assign task_switched_bit     = machine_status_word[pcr_pkg::MSW_TS];
    assign active                = (state == ST_RUN) && !halted;

    pcr_class u_class (
        .op  (op),
        .cls (cls)
    );

    pcr_ext_check u_ext (
        .mp        (extension_present_bit),
        .em        (emulate_extension_bit),
        .ts        (task_switched_bit),
        .is_esc    (op == pcr_pkg::OP_ESC),
        .is_wait   (op == pcr_pkg::OP_WAIT),
        .ext_fault (ext_fault)
    );

////////////////////////////////////////////////////////////////////////////////
// Privilege checks, decided before any state is touched

    // Level zero only for privileged; level at or below limit for trusted
    assign priv_ok   = (current_privilege_level == pcr_pkg::PL_ZERO);
    assign trust_ok  = (current_privilege_level <= io_privilege_limit);
    assign gp_fault  = ((cls == pcr_pkg::CLS_PRIV) && !priv_ok)
                     || ((cls == pcr_pkg::CLS_TRUST) && !trust_ok);
    assign any_fault = gp_fault || ext_fault;
    // Fault masks execution so no register changes on a refused op
    assign do_exec   = issue && active && !any_fault;

    // Flag restore: interrupt flag protected by level; limit field protected on flag pop only
    always_comb begin
        next_flags = op_data;
        if (!trust_ok) begin
            next_flags[pcr_pkg::FLG_IF] = flags[pcr_pkg::FLG_IF];
        end
        if ((op == pcr_pkg::OP_FLAG_POP) && !priv_ok) begin
            next_flags[pcr_pkg::FLG_IO_PRIVILEGE_LIMIT_HI:pcr_pkg::FLG_IO_PRIVILEGE_LIMIT_LO] = io_privilege_limit;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Reset sequencing

    // Hold off for the internal interval before the first fetch
    always_ff @(posedge mclk) begin
        if (srst) begin
            state    <= ST_RESET;
            init_cnt <= 3'h0;
        end else begin
            case (state)
                ST_RESET: begin
                    state    <= ST_INIT;
                    init_cnt <= 3'h1;
                end
                ST_INIT: begin
                    if (init_cnt >= pcr_pkg::RST_INTERVAL - 3'h1) begin
                        state <= ST_FETCH;
                    end
                    init_cnt <= init_cnt + 3'h1;
                end
                ST_FETCH: begin
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    // Run indication and the first fetch from the initialization area
    always_ff @(posedge mclk) begin
        if (srst) begin
            run        <= 1'b0;
            fetch_req  <= 1'b0;
            fetch_addr <= pcr_pkg::RST_FETCH;
        end else begin
            run        <= (state == ST_FETCH) || (state == ST_RUN);
            fetch_req  <= (state == ST_FETCH);
            fetch_addr <= pcr_pkg::RST_FETCH;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Fault reporting and retirement

    // Fault pulse with vector and code; general protection code is zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            fault      <= 1'b0;
            fault_vec  <= 8'h00;
            fault_code <= 16'h0000;
            retired    <= 1'b0;
        end else begin
            fault   <= issue && active && any_fault;
            retired <= do_exec;
            if (issue && active && gp_fault) begin
                fault_vec  <= pcr_pkg::VEC_GP;
                fault_code <= pcr_pkg::GP_ERR_CODE;
            end else if (issue && active && ext_fault) begin
                fault_vec  <= pcr_pkg::VEC_NM;
                fault_code <= pcr_pkg::GP_ERR_CODE;
            end
        end
    end

    // Halt is privileged; it stops issue until reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            halted <= 1'b0;
        end else if (do_exec && (op == pcr_pkg::OP_HLT)) begin
            halted <= 1'b1;
        end
    end

    // Descriptor accesses set accessed or busy bits in memory
    always_ff @(posedge mclk) begin
        if (srst) begin
            desc_wb      <= 1'b0;
            desc_wb_addr <= 24'h000000;
        end else begin
            desc_wb <= active && desc_used;
            if (active && desc_used) begin
                desc_wb_addr <= desc_addr;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Architectural registers

    // Flag word; interrupts off at reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags <= pcr_pkg::RST_FLAGS;
        end else if (do_exec) begin
            case (op)
                pcr_pkg::OP_FLAG_POP, pcr_pkg::OP_INTERRUPT_RETURN: begin
                    flags <= next_flags;
                end
                pcr_pkg::OP_STI: begin
                    flags[pcr_pkg::FLG_IF] <= 1'b1;
                end
                pcr_pkg::OP_CLI: begin
                    flags[pcr_pkg::FLG_IF] <= 1'b0;
                end
                default: begin
                    flags <= flags;
                end
            endcase
        end
    end

    // Status word; protection enable is sticky once set
    always_ff @(posedge mclk) begin
        if (srst) begin
            machine_status_word <= pcr_pkg::RST_MSW;
        end else if (do_exec && (op == pcr_pkg::OP_LOAD_MACHINE_STATUS)) begin
            // Upper bits kept as they were; only low four are meaningful
            machine_status_word <= (machine_status_word & ~pcr_pkg::MSW_LOW_MASK)
                                 | (op_data & pcr_pkg::MSW_LOW_MASK);
            if (protection_enable_bit) begin
                machine_status_word[pcr_pkg::MSW_PE] <= 1'b1;
            end
        end else if (do_exec && (op == pcr_pkg::OP_CLEAR_TASK_SWITCHED)) begin
            machine_status_word[pcr_pkg::MSW_TS] <= 1'b0;
        end
    end

    // Code segment and instruction pointer
    always_ff @(posedge mclk) begin
        if (srst) begin
            ip      <= pcr_pkg::RST_IP;
            cs_sel  <= pcr_pkg::RST_CS_SEL;
            cs_base <= pcr_pkg::RST_CS_BASE;
        end else if (do_exec && (op == pcr_pkg::OP_LOAD_CS)) begin
            cs_sel <= op_data;
            if (!protection_enable_bit) begin
                cs_base <= op_base & pcr_pkg::REAL_BASE_MASK;
            end else begin
                cs_base <= op_base;
            end
        end
    end

    // Data, extra and stack segments share one reset image
    always_ff @(posedge mclk) begin
        if (srst) begin
            seg_sel   <= pcr_pkg::RST_SEG_SEL;
            seg_base  <= pcr_pkg::RST_SEG_BASE;
            seg_limit <= pcr_pkg::RST_LIMIT;
            seg_prot  <= 1'b0;
        end
    end

    // Interrupt table register
    always_ff @(posedge mclk) begin
        if (srst) begin
            idt_base  <= pcr_pkg::RST_IDT_BASE;
            idt_limit <= pcr_pkg::RST_IDT_LIM;
        end else if (do_exec && (op == pcr_pkg::OP_LOAD_INTERRUPT_TABLE_REG)) begin
            idt_base  <= op_base;
            idt_limit <= op_data;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Assertions

    property p_priv_fault;
        @(posedge mclk) disable iff (srst)
        issue && active && (cls == pcr_pkg::CLS_PRIV) && (current_privilege_level != pcr_pkg::PL_ZERO)
        |=> fault && (fault_vec == pcr_pkg::VEC_GP) && (fault_code == pcr_pkg::GP_ERR_CODE);
    endproperty
    a_priv_fault: assert property (p_priv_fault) else $error("privileged op at nonzero level not faulted");

    property p_trust_fault;
        @(posedge mclk) disable iff (srst)
        issue && active && (cls == pcr_pkg::CLS_TRUST) && (current_privilege_level > io_privilege_limit)
        |=> fault && !retired;
    endproperty
    a_trust_fault: assert property (p_trust_fault) else $error("trusted op above limit not faulted");

    property p_trust_ok;
        @(posedge mclk) disable iff (srst)
        issue && active && (cls == pcr_pkg::CLS_TRUST) && !ext_fault
        && (current_privilege_level <= io_privilege_limit) |=> retired && !fault;
    endproperty
    a_trust_ok: assert property (p_trust_ok) else $error("trusted op within limit refused");

    property p_if_keep;
        @(posedge mclk) disable iff (srst)
        issue && active && ((op == pcr_pkg::OP_FLAG_POP) || (op == pcr_pkg::OP_INTERRUPT_RETURN))
        && (current_privilege_level > io_privilege_limit)
        |=> flags[pcr_pkg::FLG_IF] == $past(flags[pcr_pkg::FLG_IF]);
    endproperty
    a_if_keep: assert property (p_if_keep) else $error("interrupt flag changed at untrusted level");

    property p_io_privilege_limit_keep;
        @(posedge mclk) disable iff (srst)
        issue && active && (op == pcr_pkg::OP_FLAG_POP) && (current_privilege_level != pcr_pkg::PL_ZERO)
        |=> $stable(flags[pcr_pkg::FLG_IO_PRIVILEGE_LIMIT_HI:pcr_pkg::FLG_IO_PRIVILEGE_LIMIT_LO]);
    endproperty
    a_io_privilege_limit_keep: assert property (p_io_privilege_limit_keep) else $error("limit field changed by pop above level zero");

    property p_reset_quiet;
        @(posedge mclk) srst |=> !run && !fetch_req && !retired;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("activity during reset");

    property p_first_fetch;
        @(posedge mclk) disable iff (srst)
        $fell(srst) |-> !fetch_req [*5] ##1 fetch_req && (fetch_addr == pcr_pkg::RST_FETCH);
    endproperty
    a_first_fetch: assert property (p_first_fetch) else $error("first fetch timing or address wrong");

    property p_reset_vals;
        @(posedge mclk) srst |=> (flags == pcr_pkg::RST_FLAGS) && (ip == pcr_pkg::RST_IP)
            && (cs_sel == pcr_pkg::RST_CS_SEL) && (idt_limit == pcr_pkg::RST_IDT_LIM) && !seg_prot;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_pe_sticky;
        @(posedge mclk) disable iff (srst)
        protection_enable_bit |=> protection_enable_bit;
    endproperty
    a_pe_sticky: assert property (p_pe_sticky) else $error("protection enable cleared");

    property p_real_cs;
        @(posedge mclk) disable iff (srst)
        do_exec && (op == pcr_pkg::OP_LOAD_CS) && !protection_enable_bit |=> cs_base[23:20] == 4'h0;
    endproperty
    a_real_cs: assert property (p_real_cs) else $error("real mode code base upper bits set");

    property p_esc_em;
        @(posedge mclk) disable iff (srst)
        issue && active && (op == pcr_pkg::OP_ESC) && emulate_extension_bit && !extension_present_bit
        |=> fault && (fault_vec == pcr_pkg::VEC_NM);
    endproperty
    a_esc_em: assert property (p_esc_em) else $error("escape under emulation not faulted");

    property p_no_ext;
        @(posedge mclk) disable iff (srst)
        issue && active && ((op == pcr_pkg::OP_ESC) || (op == pcr_pkg::OP_WAIT))
        && extension_present_bit && !task_switched_bit && !emulate_extension_bit |=> !fault;
    endproperty
    a_no_ext: assert property (p_no_ext) else $error("extension fault with coprocessor present");

    c_priv_fault: cover property (@(posedge mclk) disable iff (srst) fault && (fault_vec == pcr_pkg::VEC_GP));
    c_ext_fault:  cover property (@(posedge mclk) disable iff (srst) fault && (fault_vec == pcr_pkg::VEC_NM));
    c_fetch:      cover property (@(posedge mclk) disable iff (srst) fetch_req);
    c_pe_set:     cover property (@(posedge mclk) disable iff (srst) $rose(protection_enable_bit));

endmodule

// *** test/pcr_unit_tb_top.sv ***
// Self-checking testbench for the privilege check and reset state unit
`timescale 1ns/10ps
module pcr_unit_tb_top;
////////////////////////////////////////////////////////////////////////
    logic                mclk;
    logic                srst;
    logic                issue;
    logic                desc_used;
    pcr_pkg::pcr_op_t    op;
    logic [15:0]         op_data;
    logic [23:0]         op_base;
    logic [23:0]         desc_addr;
    logic [1:0]          current_privilege_level;
    logic                run, fetch_req, halted, retired, fault, desc_wb, seg_prot;
    logic [7:0]          fault_vec;
    logic [15:0]         fault_code, flags, machine_status_word, ip, cs_sel, seg_sel, seg_limit, idt_limit;
    logic [23:0]         fetch_addr, desc_wb_addr, cs_base, seg_base, idt_base;
    int                  mismatches;
    int                  check_count;
    pcr_pkg::pcr_op_t    priv[7] = '{pcr_pkg::OP_LOAD_GLOBAL_TABLE_REG, pcr_pkg::OP_LOAD_LOCAL_TABLE_REG, pcr_pkg::OP_LTR, pcr_pkg::OP_LOAD_INTERRUPT_TABLE_REG,
                                     pcr_pkg::OP_LOAD_MACHINE_STATUS, pcr_pkg::OP_CLEAR_TASK_SWITCHED, pcr_pkg::OP_HLT};
    pcr_pkg::pcr_op_t    trust[11] = '{pcr_pkg::OP_IN, pcr_pkg::OP_INW, pcr_pkg::OP_OUT, pcr_pkg::OP_OUTW,
                                       pcr_pkg::OP_BLOCK_INPUT_BYTE, pcr_pkg::OP_INSW, pcr_pkg::OP_OUTSB, pcr_pkg::OP_BLOCK_OUTPUT_WORD,
                                       pcr_pkg::OP_STI, pcr_pkg::OP_CLI, pcr_pkg::OP_LOCK};
////////////////////////////////////////////////////////////////////////
    pcr_unit dut (.mclk, .srst, .issue, .op, .op_data, .op_base, .desc_used, .desc_addr,
        .current_privilege_level, .run, .fetch_req, .fetch_addr, .halted, .retired, .fault, .fault_vec,
        .fault_code, .desc_wb, .desc_wb_addr, .flags, .machine_status_word, .ip, .cs_sel, .cs_base,
        .seg_sel, .seg_base, .seg_limit, .seg_prot, .idt_base, .idt_limit);
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Compare and count; every mismatch is reported at once
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Verdict in one place for normal end and watchdog alike
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Issue one op; e: 0 retire, 1 fault, 2 neither (ignored issue)
    task automatic exec(input pcr_pkg::pcr_op_t o, input logic [15:0] d, input logic [1:0] lvl,
                        input logic [1:0] e, input logic [7:0] vec);
        int n;
        @(posedge mclk);
        #2;
        op = o;
        op_data = d;
        current_privilege_level = lvl;
        issue = 1'b1;
        @(posedge mclk);
        #2;
        issue = 1'b0;
        n = 0;
        while (retired !== 1'b1 && fault !== 1'b1 && n < 3) begin
            @(posedge mclk);
            #2;
            n++;
        end
        chk({fault, retired}, (e == 2'd0) ? 2'b01 : (e == 2'd1) ? 2'b10 : 2'b00);
        if (e == 2'd1) chk({fault_vec, fault_code}, {vec, pcr_pkg::GP_ERR_CODE});
    endtask
    // Reset with an issue pending; nothing may start until the post-reset interval ends
    task automatic reset_seq();
        int n;
        srst = 1'b1;
        issue = 1'b1;
        repeat (16) @(posedge mclk);
        #2;
        chk({run, fetch_req, retired, fault}, 4'h0);
        chk(flags, pcr_pkg::RST_FLAGS);
        chk(machine_status_word, pcr_pkg::RST_MSW);
        chk({ip, cs_sel}, {pcr_pkg::RST_IP, pcr_pkg::RST_CS_SEL});
        chk({idt_base, idt_limit[7:0]}, {24'h000000, 8'hFF});
        chk(idt_limit, 16'h03FF);
        chk({seg_base, seg_prot}, {pcr_pkg::RST_SEG_BASE, 1'b0});
        chk({seg_sel, seg_limit}, {16'h0000, 16'hFFFF});
        chk(cs_base, 24'hFF0000);
        srst = 1'b0;
        issue = 1'b0;
        n = 0;
        while (fetch_req !== 1'b1 && n < 10) begin
            @(posedge mclk);
            #2;
            n++;
        end
        chk(n >= 4 && n <= 6, 1);
        chk(fetch_addr, 24'hFFFFF0);
        @(posedge mclk);
        #2;
        chk(run, 1'b1);
        $display("reset test done");
    endtask
    // Watchdog: far beyond the roughly 150 cycles the tests need
    initial begin
        #(25 * 5000);
        mismatches++;
        finish_test();
    end
////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        srst = 1'b1;
        issue = 1'b0;
        op = pcr_pkg::OP_NONE;
        op_data = 16'h0000;
        op_base = 24'h000000;
        desc_used = 1'b0;
        desc_addr = 24'h000000;
        current_privilege_level = 2'h0;
        mismatches = 0;
        check_count = 0;
        reset_seq();
        foreach (priv[i]) exec(priv[i], 16'h0001, 2'h3, 2'd1, pcr_pkg::VEC_GP);
        chk({machine_status_word, halted}, {pcr_pkg::RST_MSW, 1'b0});
        foreach (trust[i]) exec(trust[i], 16'h0000, 2'h1, 2'd1, pcr_pkg::VEC_GP);
        foreach (trust[i]) exec(trust[i], 16'h0000, 2'h0, 2'd0, 8'h00);
        $display("privilege test done");
        exec(pcr_pkg::OP_FLAG_POP, 16'h2202, 2'h0, 2'd0, 8'h00);
        chk({flags[13:12], flags[9]}, 3'b101);
        exec(pcr_pkg::OP_FLAG_POP, 16'h0002, 2'h3, 2'd0, 8'h00);
        chk({flags[13:12], flags[9]}, 3'b101);
        exec(pcr_pkg::OP_FLAG_POP, 16'h0002, 2'h2, 2'd0, 8'h00);
        chk({flags[13:12], flags[9]}, 3'b100);
        exec(pcr_pkg::OP_STI, 16'h0000, 2'h3, 2'd1, pcr_pkg::VEC_GP);
        chk(flags[9], 1'b0);
        exec(pcr_pkg::OP_STI, 16'h0000, 2'h2, 2'd0, 8'h00);
        exec(pcr_pkg::OP_INTERRUPT_RETURN, 16'h0002, 2'h3, 2'd0, 8'h00);
        chk(flags[9], 1'b1);
        $display("flag test done");
        exec(pcr_pkg::OP_LOAD_MACHINE_STATUS, 16'h0004, 2'h0, 2'd0, 8'h00);
        chk(machine_status_word, 16'hFFF4);
        exec(pcr_pkg::OP_ESC, 16'h0000, 2'h3, 2'd1, pcr_pkg::VEC_NM);
        exec(pcr_pkg::OP_LOAD_MACHINE_STATUS, 16'h000A, 2'h0, 2'd0, 8'h00);
        exec(pcr_pkg::OP_WAIT, 16'h0000, 2'h3, 2'd1, pcr_pkg::VEC_NM);
        exec(pcr_pkg::OP_CLEAR_TASK_SWITCHED, 16'h0000, 2'h0, 2'd0, 8'h00);
        chk(machine_status_word, 16'hFFF2);
        exec(pcr_pkg::OP_ESC, 16'h0000, 2'h3, 2'd0, 8'h00);
        exec(pcr_pkg::OP_WAIT, 16'h0000, 2'h3, 2'd0, 8'h00);
        op_base = 24'hABCDEF;
        exec(pcr_pkg::OP_LOAD_CS, 16'h1234, 2'h3, 2'd0, 8'h00);
        chk({cs_sel, cs_base}, {16'h1234, 24'h0BCDEF});
        exec(pcr_pkg::OP_LOAD_MACHINE_STATUS, 16'h0001, 2'h0, 2'd0, 8'h00);
        exec(pcr_pkg::OP_LOAD_MACHINE_STATUS, 16'h0000, 2'h0, 2'd0, 8'h00);
        chk(machine_status_word[0], 1'b1);
        $display("status test done");
        @(posedge mclk);
        #2;
        desc_used = 1'b1;
        desc_addr = 24'h123456;
        @(posedge mclk);
        #2;
        desc_used = 1'b0;
        repeat (3) if (desc_wb !== 1'b1) @(posedge mclk) #2;
        chk({desc_wb, desc_wb_addr}, {1'b1, 24'h123456});
        exec(pcr_pkg::OP_HLT, 16'h0000, 2'h0, 2'd0, 8'h00);
        chk(halted, 1'b1);
        exec(pcr_pkg::OP_LOAD_MACHINE_STATUS, 16'h0008, 2'h0, 2'd2, 8'h00);
        chk(machine_status_word[3], 1'b0);
        reset_seq();
        chk(halted, 1'b0);
        finish_test();
    end
endmodule
